// ==== core/pci_pkg.sv ====
package pci_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_RISE_EDGE_ENABLE = 4'h0;
    localparam logic [3:0] REG_FALL_EDGE_ENABLE = 4'h1;
    localparam logic [3:0] REG_PIN_CHANGE_FLAGS = 4'h2;
    localparam logic [3:0] REG_CONTROL          = 4'h3;
    localparam logic [3:0] REG_STATUS           = 4'h4;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         PIN_COUNT          = 6;
    localparam int         CTRL_IRQ_EN_BIT    = 0;
    localparam int         CTRL_SLEEP_BIT     = 1;
    localparam int         STAT_SUMMARY_BIT   = 0;
    localparam int         STAT_SLEEP_BIT     = 1;
    localparam logic [5:0] RESET_ENABLES      = 6'h00;
    localparam logic [5:0] RESET_FLAGS        = 6'h00;
    localparam logic [7:0] READ_ZERO          = 8'h00;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pci_bus_req_t;

endpackage

// ==== core/pci_sync.sv ====
`timescale 1ns/10ps
module pci_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pci_sync_state_t;

    pci_sync_state_t state;
    pci_sync_state_t next_state;

    // ------------------------------------------------------------
    // two stage synchroniser
    // ------------------------------------------------------------
    always_comb begin
        next_state.meta   = asyncIn;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign syncOut = state.stable;
endmodule

// ==== core/pci_edge_detect.sv ====
`timescale 1ns/10ps
module pci_edge_detect #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    localparam logic [1:0] WARM_DONE = 2'h3;

    typedef struct packed {
        logic [1:0]       warm;
        logic [WIDTH-1:0] prev;
    } pci_edge_state_t;

    pci_edge_state_t state;
    pci_edge_state_t next_state;

    // ------------------------------------------------------------
    // compare sample with previous one
    // ------------------------------------------------------------
    // synchroniser shows zero for two cycles after reset, so compare only
    // once prev holds a real pin sample; the start level is no edge
    always_comb begin
        next_state.warm = (state.warm == WARM_DONE) ? state.warm : state.warm + 2'h1;
        next_state.prev = level;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise = (state.warm == WARM_DONE) ? (level & ~state.prev) : '0;
    assign fall = (state.warm == WARM_DONE) ? (~level & state.prev) : '0;
endmodule

// ==== core/pci_pin_change_irq.sv ====
`timescale 1ns/10ps
// Summary of operation
// - change in sleep with enable wakes core
// - sleep edges land in flags before wake
// - rise enable bits 5..0 gate rising detection
// - fall enable bits 5..0 gate falling detection
// - enabled edge sets its pin flag
// - flags read zero until set, software clears
// - bits 7 and 6 read zero
// - all enables and flags reset zero
// - flags software writable, hardware settable
// - detection continues while interrupt disabled
// - summary flag ORs all pin flags
// - edge during flag write wins
module pci_pin_change_irq #(
    parameter int PINS = pci_pkg::PIN_COUNT
) (
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic [7:0]      regAddr,
    input  wire logic [7:0]      regWdata,
    input  wire logic            regWrite,
    input  wire logic            regRead,
    output logic      [7:0]      regRdata,
    input  wire logic [PINS-1:0] port_pin,
    input  wire logic            coreSleeping,
    output logic                 change_irq_summary,
    output logic                 changeIrq,
    output logic                 wakeCore
);
    typedef struct packed {
        logic [PINS-1:0] rise_detect_enable;
        logic [PINS-1:0] fall_detect_enable;
        logic [PINS-1:0] pin_change_flag;
        logic            change_irq_enable;
        logic [7:0]      rdata;
    } pci_state_t;

    pci_state_t           state;
    pci_state_t           next_state;
    pci_pkg::pci_bus_req_t req;
    logic [PINS-1:0]      pinSync;
    logic [PINS-1:0]      pinRise;
    logic [PINS-1:0]      pinFall;
    logic [PINS-1:0]      edgeHit;
    logic                 anyFlag;
    logic [7:0]           readMux;

    assign req.addr  = regAddr[3:0];
    assign req.wdata = regWdata;
    assign req.wr    = regWrite;
    assign req.rd    = regRead;

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    pci_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .asyncIn (port_pin),
        .syncOut (pinSync)
    );

    pci_edge_detect #(
        .WIDTH (PINS)
    ) u_edge (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .level   (pinSync),
        .rise    (pinRise),
        .fall    (pinFall)
    );

    // detection runs on the system clock, so it must stay alive in sleep
    assign edgeHit = (pinRise & state.rise_detect_enable)
                   | (pinFall & state.fall_detect_enable);

    assign anyFlag = |state.pin_change_flag;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // upper bits of each 6-bit register are padded with zero
    always_comb begin
        readMux = pci_pkg::READ_ZERO;
        if (regAddr[7:4] == 4'h0) begin
            case (req.addr)
                pci_pkg::REG_RISE_EDGE_ENABLE: begin
                    readMux[PINS-1:0] = state.rise_detect_enable;
                end
                pci_pkg::REG_FALL_EDGE_ENABLE: begin
                    readMux[PINS-1:0] = state.fall_detect_enable;
                end
                pci_pkg::REG_PIN_CHANGE_FLAGS: begin
                    readMux[PINS-1:0] = state.pin_change_flag;
                end
                pci_pkg::REG_CONTROL: begin
                    readMux[pci_pkg::CTRL_IRQ_EN_BIT] = state.change_irq_enable;
                end
                pci_pkg::REG_STATUS: begin
                    readMux[pci_pkg::STAT_SUMMARY_BIT] = anyFlag;
                    readMux[pci_pkg::STAT_SLEEP_BIT]   = coreSleeping;
                end
                default: begin
                    readMux = pci_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_state.rdata = req.rd ? readMux : pci_pkg::READ_ZERO;
        if (req.wr && regAddr[7:4] == 4'h0) begin
            case (req.addr)
                pci_pkg::REG_RISE_EDGE_ENABLE: begin
                    next_state.rise_detect_enable = req.wdata[PINS-1:0];
                end
                pci_pkg::REG_FALL_EDGE_ENABLE: begin
                    next_state.fall_detect_enable = req.wdata[PINS-1:0];
                end
                pci_pkg::REG_PIN_CHANGE_FLAGS: begin
                    // a write loads the flags directly from write data, so it can set or clear any flag
                    next_state.pin_change_flag = req.wdata[PINS-1:0];
                end
                pci_pkg::REG_CONTROL: begin
                    next_state.change_irq_enable = req.wdata[pci_pkg::CTRL_IRQ_EN_BIT];
                end
                default: begin
                    next_state.change_irq_enable = state.change_irq_enable;
                end
            endcase
        end
        // hardware set wins over any write in the same cycle
        next_state.pin_change_flag = next_state.pin_change_flag | edgeHit;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state.rise_detect_enable <= pci_pkg::RESET_ENABLES;
            state.fall_detect_enable <= pci_pkg::RESET_ENABLES;
            state.pin_change_flag    <= pci_pkg::RESET_FLAGS;
            state.change_irq_enable  <= 1'b0;
            state.rdata              <= pci_pkg::READ_ZERO;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdata           = state.rdata;
    assign change_irq_summary = anyFlag;
    assign changeIrq          = anyFlag & state.change_irq_enable;
    // flag is already registered when wake rises, so the core sees it first
    assign wakeCore           = changeIrq & coreSleeping;
endmodule

// ==== tb/pci_pin_change_irq_asserts.sv ====
`timescale 1ns/10ps
module pci_irq_chk #(
    parameter int PINS = 6
) (
    input wire logic            clk_sys,
    input wire logic            sys_rst,
    input wire logic [7:0]      regAddr,
    input wire logic [7:0]      regWdata,
    input wire logic            regWrite,
    input wire logic            regRead,
    input wire logic [7:0]      regRdata,
    input wire logic [PINS-1:0] port_pin,
    input wire logic            coreSleeping,
    input wire logic            change_irq_summary,
    input wire logic            changeIrq,
    input wire logic            wakeCore
);
    // ----
    // cycles since the pins last moved
    // ----
    logic [PINS-1:0] prevPin;
    logic [3:0]      quiet;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prevPin <= port_pin;
            quiet   <= 4'h0;
        end else begin
            prevPin <= port_pin;
            quiet   <= (port_pin != prevPin) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_wake; wakeCore == (changeIrq && coreSleeping); endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_irq; changeIrq |-> change_irq_summary; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_rsv; regRdata[7:6] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("upper bits set");
    property p_sum; $past(regRead && regAddr == 8'h02)
        |-> ((|regRdata[5:0]) == $past(change_irq_summary)); endproperty
    a_sum: assert property (p_sum) else $error("summary not or");
    property p_rst; $past(sys_rst) |-> !change_irq_summary; endproperty
    a_rst: assert property (p_rst) else $error("flag after reset");
    // pin motion needs three cycles to reach a flag; six gives margin
    property p_quiet; $rose(change_irq_summary) |-> $past(regWrite) || quiet < 4'h6; endproperty
    a_quiet: assert property (p_quiet) else $error("flag without edge");
    property p_wr; $past(regWrite && regAddr == 8'h02 && regWdata[5:0] == 6'h00)
        && quiet >= 4'h6 |-> !change_irq_summary; endproperty
    a_wr: assert property (p_wr) else $error("clear failed");
    property p_unm; $past(regRead && regAddr > 8'h04) |-> regRdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped nonzero");
endmodule
bind pci_pin_change_irq pci_irq_chk #(.PINS(PINS)) pci_irq_chk_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .port_pin(port_pin),
    .coreSleeping(coreSleeping), .change_irq_summary(change_irq_summary),
    .changeIrq(changeIrq), .wakeCore(wakeCore));

// ==== tb/pci_pin_model.sv ====
`timescale 1ns/10ps
module pci_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [5:0] pinReq,
    output logic      [5:0] port_pin
);
    // pins move 3 ns off the edge, so the synchroniser sees a true async input
    initial port_pin = 6'h00;
    always @(posedge clk_sys) port_pin <= #3 pinReq;
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic       clk_sys = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic [5:0] pinReq = 6'h00, port_pin, re, fe, flags, old;
    logic       summary, changeIrq, wakeCore, ien, coreSleeping = 1'b0;
    int         seed = 32'hEA4F, fail_count = 0, tests_run = 0, cyc = 0, d;
    pci_pin_change_irq pci_pin_change_irq_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .port_pin(port_pin), .coreSleeping(coreSleeping),
        .change_irq_summary(summary), .changeIrq(changeIrq), .wakeCore(wakeCore));
    pci_pin_model pci_pin_model_i (.clk_sys(clk_sys), .pinReq(pinReq), .port_pin(port_pin));
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 chk("rdata", regRdata, e);
    endtask
    // ----
    // drive pins, then let the synchroniser settle before predicting flags
    // ----
    task automatic pin(input logic [5:0] v);
        @(posedge clk_sys);
        pinReq <= v;
        repeat (7) @(posedge clk_sys);
        flags = flags | (v & ~old & re) | (~v & old & fe);
        old   = v;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (d = 0; d < 6; d++) rd(d[7:0], 8'h00);
        rd(8'h12, 8'h00);
        wr(8'h00, 8'hFF); rd(8'h00, 8'h3F);
        wr(8'h01, 8'hFF); rd(8'h01, 8'h3F);
        wr(8'h12, 8'h3F); rd(8'h02, 8'h00);
        wr(8'h02, 8'hFF); rd(8'h02, 8'h3F);
        wr(8'h02, 8'h00);
        flags = 6'h00;
        old   = 6'h00;
        for (d = 0; d < 40; d++) begin
            re  = 6'($random(seed));
            fe  = 6'($random(seed));
            ien = 1'($random(seed));
            wr(8'h00, {2'h0, re});
            wr(8'h01, {2'h0, fe});
            wr(8'h03, {7'h00, ien});
            coreSleeping <= 1'($random(seed));
            pin(6'($random(seed)));
            rd(8'h02, {2'h0, flags});
            chk("summary", {7'h00, summary}, {7'h00, |flags});
            chk("irq", {7'h00, changeIrq}, {7'h00, ien & |flags});
            chk("wake", {7'h00, wakeCore}, {7'h00, ien & |flags & coreSleeping});
            rd(8'h03, {7'h00, ien});
            rd(8'h04, {6'h00, coreSleeping, |flags});
            if (d[0]) begin
                // zero write clears every flag already seen
                wr(8'h02, {2'h0, flags & ~flags});
                flags = 6'h00;
            end
        end
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h00);
        re = 6'h01;
        fe = 6'h00;
        for (d = 4; d < 6; d++) begin
            pin({old[5:1], 1'b0});
            wr(8'h02, 8'h00);
            @(posedge clk_sys);
            pinReq <= {old[5:1], 1'b1};
            repeat (d - 2) @(posedge clk_sys);
            wr(8'h02, 8'h00);
            repeat (4) @(posedge clk_sys);
            rd(8'h02, {7'h00, d == 4});
            old = pinReq;
        end
        report_and_stop();
    end
endmodule
